// *** src/codec_core_map.svh ***
`ifndef CODEC_CORE_MAP_SVH
`define CODEC_CORE_MAP_SVH

// ----------------------------------------------------------------
// Control register indices and byte addresses
// ----------------------------------------------------------------
`define CTRL_IDX_A        3'h0
`define CTRL_IDX_B        3'h1
`define CTRL_IDX_C        3'h2
`define CTRL_IDX_D        3'h3
`define CTRL_IDX_E        3'h4
`define CTRL_IDX_F        3'h5
`define CTRL_COUNT        6
`define ADDR_ADC_WORD     8'h18
`define ADDR_DAC_WORD     8'h1C
`define CTRL_RESET_VALUE  8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define A_DATA_MODE_BIT   0
`define A_MIXED_MODE_BIT  1
`define A_SOFT_RESET_BIT  7
`define B_RATE_LSB        0
`define B_SCLK_LSB        2
`define B_MDIV_LSB        4
`define C_REF_EN_BIT      6
`define D_GAIN_LSB        4
`define D_MUTE_BIT        7
`define E_BYPASS_BIT      5
`define WORD_FLAG_BIT     15
`define WORD_RW_BIT       14
`define WORD_DEV_LSB      11
`define WORD_REG_LSB      8

// ----------------------------------------------------------------
// Timing counts in device master clock ticks, last serial frame bit, DAC feedback full-scale levels
// ----------------------------------------------------------------
`define OVERSAMPLE_TICKS  3'h7
`define FRAME_LAST_BIT    4'hF
`define DAC_POS_FULL      19'sh07FFF
`define DAC_NEG_FULL      19'sh78000

`endif

// *** src/codec_core_pkg.sv ***
package codec_core_pkg;

    // Serial link sequencer states
    typedef enum logic
    {
        LINK_IDLE,
        LINK_SHIFT
    } link_state_t;

    // AXI response codes
    typedef logic [1:0] axi_resp_t;

    typedef logic [7:0] ctrl_byte_t;

endpackage

// *** src/codec_digital_core.sv ***
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "codec_core_map.svh"
module codec_digital_core
    import codec_core_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog side
    input  wire logic        adc_bit_i,
    output logic             dac_bit_o,
    output logic [2:0]       output_gain_select_o,
    output logic             mute_o,
    output logic             reference_out_enable_o,
    // Serial link
    input  wire logic        sdi_i,
    output logic             sclk_o,
    output logic             sdo_o,
    output logic             output_frame_sync_o
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Codes 101..111 fall back to divide-by-one
    function automatic logic [2:0] mclk_ratio(input logic [2:0] code);
        mclk_ratio = (code > 3'h4) ? 3'h1 : code + 3'h1;
    endfunction

    // Serial bit length in device clock ticks: 8,4,2,1
    function automatic logic [3:0] sclk_ratio(input logic [1:0] code);
        sclk_ratio = 4'h8 >> code;
    endfunction

    // log2 of N: 8,7,6,5 for codes 00..11, so M = 8N
    function automatic logic [3:0] log2_n(input logic [1:0] code);
        log2_n = 4'h8 - {2'h0, code};
    endfunction

    // ----------------------------------------------------------------
    // Registers and synchronisers
    // ----------------------------------------------------------------
    ctrl_byte_t   ctrl_reg [0:`CTRL_COUNT-1];
    logic [1:0]   adc_sync_reg;
    logic [1:0]   sdi_sync_reg;
    logic         adc_bit_s;
    logic         sdi_s;

    // Pins from the analog and host sides pass two flip-flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            adc_sync_reg <= 2'h0;
            sdi_sync_reg <= 2'h0;
        end
        else if (ce_i)
        begin
            adc_sync_reg <= {adc_sync_reg[0], adc_bit_i};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
        end
    end
    assign adc_bit_s = adc_sync_reg[1];
    assign sdi_s     = sdi_sync_reg[1];

    // ----------------------------------------------------------------
    // Clock dividers
    // ----------------------------------------------------------------
    logic [2:0]   mdiv_reg;
    logic [2:0]   os_reg;
    logic [10:0]  rate_reg;
    logic         dm_tick;
    logic         os_tick;
    logic         sample_tick;
    logic [10:0]  rate_last;

    assign dm_tick   = (mdiv_reg >= mclk_ratio(ctrl_reg[`CTRL_IDX_B][`B_MDIV_LSB +: 3]) - 3'h1);
    assign rate_last = (11'h8 << log2_n(ctrl_reg[`CTRL_IDX_B][`B_RATE_LSB +: 2])) - 11'h1;
    assign os_tick     = dm_tick && (os_reg == `OVERSAMPLE_TICKS);
    assign sample_tick = dm_tick && (rate_reg >= rate_last);

    // Master divider, oversample and sample-rate counters share one phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mdiv_reg <= 3'h0;
            os_reg   <= 3'h0;
            rate_reg <= 11'h0;
        end
        else if (ce_i)
        begin
            mdiv_reg <= dm_tick ? 3'h0 : mdiv_reg + 3'h1;
            if (dm_tick)
            begin
                os_reg   <= os_reg + 3'h1;
                rate_reg <= sample_tick ? 11'h0 : rate_reg + 11'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Decimator
    // ----------------------------------------------------------------
    logic signed [25:0] int1_reg, int2_reg, int3_reg;
    logic signed [25:0] dly1_reg, dly2_reg, dly3_reg;
    logic signed [25:0] comb1, comb2, comb3, scaled;
    logic signed [14:0] adc_res_reg;

    assign comb1  = int3_reg - dly1_reg;
    assign comb2  = comb1 - dly2_reg;
    assign comb3  = comb2 - dly3_reg;
    // Full scale N^3 needs 3log2N+1 bits; keep the top fifteen
    assign scaled = comb3 >>> (3 * log2_n(ctrl_reg[`CTRL_IDX_B][1:0]) - 14);

    // Integrators at the oversample rate, combs at the sample rate
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {int1_reg, int2_reg, int3_reg} <= '0;
            {dly1_reg, dly2_reg, dly3_reg} <= '0;
            adc_res_reg <= 15'h0000;
        end
        else if (ce_i)
        begin
            if (os_tick)
            begin
                int1_reg <= int1_reg + (adc_bit_s ? 26'sh1 : -26'sh1);
                int2_reg <= int2_reg + int1_reg;
                int3_reg <= int3_reg + int2_reg;
            end
            if (sample_tick)
            begin
                dly1_reg <= int3_reg;
                dly2_reg <= comb1;
                dly3_reg <= comb2;
                // Positive full scale wraps one past the top code; clamp
                if (scaled > 26'sh3FFF)
                    adc_res_reg <= 15'h3FFF;
                else
                    adc_res_reg <= scaled[14:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interpolator and sigma-delta modulator
    // ----------------------------------------------------------------
    logic signed [15:0] dac_word_reg;
    logic signed [35:0] xd1_reg, xd2_reg, xd3_reg, stuff_reg;
    logic signed [35:0] ia_reg, ib_reg, ic_reg;
    logic signed [35:0] xin, e1, e2, e3, interp_full;
    logic signed [15:0] interp_out, mod_in;
    logic signed [18:0] sd_acc_reg, sd_next;

    assign xin = 36'(dac_word_reg);
    assign e1  = xin - xd1_reg;
    assign e2  = e1 - xd2_reg;
    assign e3  = e2 - xd3_reg;
    // Interpolator gain is N^2
    assign interp_full = ic_reg >>> (2 * log2_n(ctrl_reg[`CTRL_IDX_B][1:0]));
    assign interp_out  = (interp_full > 36'sh7FFF)  ? 16'sh7FFF :
                         (interp_full < -36'sh8000) ? 16'sh8000 : interp_full[15:0];
    assign mod_in  = ctrl_reg[`CTRL_IDX_E][`E_BYPASS_BIT] ? dac_word_reg : interp_out;
    assign sd_next = sd_acc_reg + 19'(mod_in) - (dac_bit_o ? `DAC_POS_FULL : `DAC_NEG_FULL);

    // Combs at the sample rate, zero-stuffed integrators at the oversample rate
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {xd1_reg, xd2_reg, xd3_reg, stuff_reg} <= '0;
            {ia_reg, ib_reg, ic_reg}                <= '0;
            sd_acc_reg <= 19'h00000;
            dac_bit_o  <= 1'b0;
        end
        else if (ce_i)
        begin
            if (sample_tick)
            begin
                xd1_reg   <= xin;
                xd2_reg   <= e1;
                xd3_reg   <= e2;
                stuff_reg <= e3;
            end
            if (os_tick)
            begin
                ia_reg     <= ia_reg + stuff_reg;
                ib_reg     <= ib_reg + ia_reg;
                ic_reg     <= ic_reg + ib_reg;
                // Sample events fall on oversample ticks; keep the new impulse
                stuff_reg  <= sample_tick ? e3 : '0;
                sd_acc_reg <= sd_next;
                dac_bit_o  <= !sd_next[18];
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial link
    // ----------------------------------------------------------------
    link_state_t  link_state;
    logic [15:0]  shift_reg;
    logic [3:0]   bit_reg;
    logic [3:0]   phase_reg;
    logic [3:0]   bit_len;
    logic         bit_end;
    logic [15:0]  rx_word;
    logic [15:0]  adc_frame;
    logic [15:0]  pend_word_reg;
    logic         pend_reg;
    logic         mode_data;
    logic         mode_mixed;
    logic         rx_done;
    logic         rx_ctrl;
    logic         ser_wr;
    logic [2:0]   ser_idx;

    assign mode_data  = ctrl_reg[`CTRL_IDX_A][`A_DATA_MODE_BIT];
    assign mode_mixed = mode_data && ctrl_reg[`CTRL_IDX_A][`A_MIXED_MODE_BIT];
    assign bit_len    = sclk_ratio(ctrl_reg[`CTRL_IDX_B][`B_SCLK_LSB +: 2]);
    assign bit_end    = dm_tick && (phase_reg == bit_len - 4'h1);
    assign rx_word    = {shift_reg[14:0], sdi_s};
    assign rx_done    = (link_state == LINK_SHIFT) && bit_end && (bit_reg == `FRAME_LAST_BIT);
    // Mixed frames carry a clear flag bit on data words
    assign adc_frame  = mode_mixed ? {1'b0, adc_res_reg} : {adc_res_reg[14], adc_res_reg};
    // Program mode takes only flagged words; data mode takes none
    assign rx_ctrl    = (!mode_data || mode_mixed) && rx_word[`WORD_FLAG_BIT];
    assign ser_wr     = rx_done && rx_ctrl && !rx_word[`WORD_RW_BIT]
                        && (rx_word[`WORD_DEV_LSB +: 3] == 3'h0)
                        && (ser_idx < 3'(`CTRL_COUNT));
    assign ser_idx    = rx_word[`WORD_REG_LSB +: 3];
    assign sdo_o      = shift_reg[15];

    // Frames start only from the codec's own sample or reply events
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            link_state          <= LINK_IDLE;
            shift_reg           <= 16'h0000;
            bit_reg             <= 4'h0;
            phase_reg           <= 4'h0;
            sclk_o              <= 1'b0;
            output_frame_sync_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (sample_tick)
            begin
                // New sample overwrites whatever was in flight
                link_state          <= LINK_SHIFT;
                shift_reg           <= adc_frame;
                bit_reg             <= 4'h0;
                phase_reg           <= 4'h0;
                sclk_o              <= 1'b1;
                output_frame_sync_o <= 1'b1;
            end
            else if (link_state == LINK_IDLE)
            begin
                sclk_o <= 1'b0;
                if (pend_reg)
                begin
                    // Forwarded or read-back word for the cascade
                    link_state          <= LINK_SHIFT;
                    shift_reg           <= pend_word_reg;
                    bit_reg             <= 4'h0;
                    phase_reg           <= 4'h0;
                    sclk_o              <= 1'b1;
                    output_frame_sync_o <= 1'b1;
                end
            end
            else if (dm_tick)
            begin
                phase_reg <= bit_end ? 4'h0 : phase_reg + 4'h1;
                // High for the first half of each bit; at DEVICE_MASTER_CLOCK/1 it stays high
                sclk_o    <= bit_end || (phase_reg + 4'h1 < (bit_len >> 1));
                if (bit_end)
                begin
                    output_frame_sync_o <= 1'b0;
                    shift_reg <= rx_word;
                    bit_reg   <= bit_reg + 4'h1;
                    if (rx_done)
                    begin
                        link_state <= LINK_IDLE;
                        sclk_o     <= 1'b0;
                    end
                end
            end
        end
    end

    // Received word: DAC update, cascade forward or register read-back
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dac_word_reg  <= 16'h0000;
            pend_word_reg <= 16'h0000;
            pend_reg      <= 1'b0;
        end
        else if (ce_i)
        begin
            if (pend_reg && link_state == LINK_IDLE && !sample_tick)
                pend_reg <= 1'b0;
            if (rx_done && !rx_ctrl && mode_data)
                dac_word_reg <= mode_mixed ? {rx_word[14:0], 1'b0} : rx_word;
            else if (rx_done && rx_ctrl && rx_word[`WORD_DEV_LSB +: 3] != 3'h0)
            begin
                // Two devices at most fit one fastest-rate frame at the slowest bit clock
                pend_word_reg <= {rx_word[15:14], rx_word[13:11] - 3'h1, rx_word[10:0]};
                pend_reg      <= 1'b1;
            end
            else if (rx_done && rx_ctrl && rx_word[`WORD_RW_BIT])
            begin
                pend_word_reg <= {rx_word[15:8],
                                  (ser_idx < 3'(`CTRL_COUNT)) ? ctrl_reg[ser_idx] : 8'h00};
                pend_reg      <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave and control registers
    // ----------------------------------------------------------------
    logic         aw_full_reg;
    logic         w_full_reg;
    logic [7:0]   aw_addr_reg;
    logic [31:0]  w_data_reg;
    logic [3:0]   w_strb_reg;
    logic         axi_wr;
    logic         axi_hit;
    logic [2:0]   axi_idx;
    logic [7:0]   wr_byte;
    logic [2:0]   wr_idx;
    logic         wr_any;

    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign axi_wr  = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign axi_idx = aw_addr_reg[4:2];
    assign axi_hit = (aw_addr_reg[7:5] == 3'h0) && (aw_addr_reg[1:0] == 2'h0)
                     && (axi_idx < 3'(`CTRL_COUNT));
    // Bus writes win over link writes in the same cycle
    assign wr_any  = (axi_wr && axi_hit && w_strb_reg[0]) || ser_wr;
    assign wr_idx  = (axi_wr && axi_hit && w_strb_reg[0]) ? axi_idx : ser_idx;
    assign wr_byte = (axi_wr && axi_hit && w_strb_reg[0]) ? w_data_reg[7:0] : rx_word[7:0];

    // Address and data accepted in either order, answered together
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (ce_i)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (axi_wr)
            begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= axi_hit ? 2'h0 : 2'h2;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // A write setting the reset bit clears the whole bank instead
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < `CTRL_COUNT; i++)
                ctrl_reg[i] <= `CTRL_RESET_VALUE;
        end
        else if (ce_i && wr_any)
        begin
            if (wr_idx == `CTRL_IDX_A && wr_byte[`A_SOFT_RESET_BIT])
            begin
                for (int i = 0; i < `CTRL_COUNT; i++)
                    ctrl_reg[i] <= `CTRL_RESET_VALUE;
            end
            else
                ctrl_reg[wr_idx] <= wr_byte;
        end
    end

    // Read data: control bytes, last ADC result, current DAC word
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end
        else if (ce_i)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                s_axi_rdata  <= 32'h0000_0000;
                if (s_axi_araddr == `ADDR_ADC_WORD)
                    s_axi_rdata <= {17'h00000, adc_res_reg};
                else if (s_axi_araddr == `ADDR_DAC_WORD)
                    s_axi_rdata <= {16'h0000, dac_word_reg};
                else if (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0
                         && s_axi_araddr[4:2] < 3'(`CTRL_COUNT))
                    s_axi_rdata <= {24'h000000, ctrl_reg[s_axi_araddr[4:2]]};
                else
                    s_axi_rresp <= 2'h2;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Static analog controls straight from the register bank
    assign output_gain_select_o   = ctrl_reg[`CTRL_IDX_D][`D_GAIN_LSB +: 3];
    assign mute_o                 = ctrl_reg[`CTRL_IDX_D][`D_MUTE_BIT];
    assign reference_out_enable_o = ctrl_reg[`CTRL_IDX_C][`C_REF_EN_BIT];

endmodule

// *** tb/codec_core_chk.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the codec core
// ----------------------------------------
module codec_core_chk (
    input logic        clk_i,
    input logic        rst_i,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [2:0]  output_gain_select_o,
    input logic        mute_o,
    input logic        reference_out_enable_o,
    input logic        sclk_o,
    input logic        output_frame_sync_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Answers stand until taken; a write answers two edges after its handshake
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    // Reset clears the static controls, so it must not be masked here
    a_rst_clear: assert property (disable iff (1'b0) rst_i |=> !mute_o
        && output_gain_select_o == 3'h0 && !reference_out_enable_o && !output_frame_sync_o)
        else $error("outputs not cleared");
    // Frame start: sync for bit 0 only, clock high for the first half
    a_fs_width: assert property ($rose(output_frame_sync_o) |->
        output_frame_sync_o[*8] ##1 !output_frame_sync_o) else $error("sync width");
    a_bit_shape: assert property ($rose(output_frame_sync_o) |->
        sclk_o[*4] ##1 !sclk_o[*4] ##1 sclk_o) else $error("bit shape");
    a_sclk_period: assert property ($rose(sclk_o) && !output_frame_sync_o |->
        $past(sclk_o, 8) && !$past(sclk_o, 9)) else $error("bit period");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_frame: cover property ($rose(output_frame_sync_o));
endmodule

// *** tb/host_link_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Host serial port stand-in
// ----------------------------------------
module host_link_model (
    input  logic        clk_i,
    input  logic        sclk_i,
    input  logic        fs_i,
    input  logic        sdo_i,
    input  logic [15:0] tx_word_i,
    output logic        sdi_o,
    output logic [15:0] rx_word_o,
    output int          frames_o
);
    logic        sclk_reg = 1'b0;
    logic [15:0] tx_reg   = 16'h0000;
    logic [15:0] rx_reg   = 16'h0000;
    int          bit_n    = 16;
    int          hold_n   = 0;
    initial {sdi_o, rx_word_o, frames_o} = '0;
    // Speaks only inside codec frames; line flips once the last bit is surely taken
    always @(posedge clk_i)
    begin
        sclk_reg <= sclk_i;
        if (hold_n > 0 && --hold_n == 0)
            sdi_o <= ~sdi_o;
        if (sclk_i && !sclk_reg)
        begin
            if (fs_i)
            begin
                tx_reg = tx_word_i;
                bit_n  = 0;
            end
            if (bit_n < 16)
                sdi_o <= tx_reg[15 - bit_n];
        end
        else if (!sclk_i && sclk_reg && bit_n < 16)
        begin
            rx_reg = {rx_reg[14:0], sdo_i};
            bit_n++;
            if (bit_n == 16)
            begin
                rx_word_o <= rx_reg;
                frames_o  <= frames_o + 1;
                hold_n = 8;
            end
        end
    end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`include "codec_core_map.svh"
`define RA(i) {3'h0, i, 2'h0}
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
    logic        clk_i, rst_i, ce_i, adc_bit_i, sdi_i, sclk_o, sdo_o, output_frame_sync_o;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        mute_o, reference_out_enable_o;
    logic [2:0]  output_gain_select_o;
    logic [15:0] tx_word, rx_word;
    int          failures, checks_done, frames;
    // 40 MHz clock
    initial
    begin
        clk_i = 0;
        forever #12.5 clk_i = ~clk_i;
    end
    codec_digital_core dut (.clk_i, .rst_i, .ce_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .adc_bit_i, .dac_bit_o(), .output_gain_select_o, .mute_o,
        .reference_out_enable_o, .sdi_i, .sclk_o, .sdo_o, .output_frame_sync_o);
    host_link_model host (.clk_i(clk_i), .sclk_i(sclk_o), .fs_i(output_frame_sync_o),
        .sdo_i(sdo_o), .tx_word_i(tx_word), .sdi_o(sdi_i), .rx_word_o(rx_word), .frames_o(frames));
    task automatic finish_test();
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One bus transfer; readies sampled mid-cycle, released at the edge that took them
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        bit done, aw_ok, w_ok, ar_ok;
        n = 0;
        done = 0;
        @(posedge clk_i);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        while (!done)
        begin
            @(negedge clk_i);
            {aw_ok, w_ok, ar_ok} = {s_axi_awready, s_axi_wready, s_axi_arready};
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            {rs, rd} = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
            @(posedge clk_i);
            if (aw_ok) s_axi_awvalid <= 0;
            if (w_ok) s_axi_wvalid <= 0;
            if (ar_ok) s_axi_arvalid <= 0;
            if (++n > 50) begin failures++; finish_test(); end
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask
    // Load the host word, set the mode, let three frames pass
    task automatic link(input logic [15:0] w, input logic [7:0] m);
        int n, f;
        tx_word <= w;
        axi(1, `RA(`CTRL_IDX_A), {24'h0, m});
        f = frames + 3;
        n = 0;
        while (frames < f)
        begin
            @(posedge clk_i);
            if (++n > 9000) begin failures++; finish_test(); end
        end
    endtask
    initial
    begin
        int c;
        {rst_i, ce_i, adc_bit_i, s_axi_wstrb} = 7'h7F;
        {failures, checks_done, tx_word, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        for (c = 0; c < `CTRL_COUNT; c++)
        begin
            axi(0, `RA(c[2:0]), 0);
            `CHK("ctrl reset", 8'h00, rd[7:0])
        end
        // Every gain code with mute on
        for (c = 0; c < 8; c++)
        begin
            axi(1, `RA(`CTRL_IDX_D), {24'h0, 1'b1, c[2:0], 4'h0});
            `CHK("gain", c[2:0], output_gain_select_o)
            `CHK("mute", 1'b1, mute_o)
        end
        axi(1, `RA(`CTRL_IDX_C), 32'h40);
        `CHK("ref enable", 1'b1, reference_out_enable_o)
        `CHK("write resp", 2'h0, rs)
        axi(0, 8'h20, 0);
        `CHK("unmapped", 2'h2, rs)
        axi(1, `RA(`CTRL_IDX_B), 32'h03);
        axi(1, `RA(`CTRL_IDX_D), 32'h00);
        axi(0, `RA(`CTRL_IDX_B), 0);
        `CHK("rate", 8'h03, rd[7:0])
        // Serial traffic in program, data and mixed mode
        link(16'h8380, 8'h00);
        `CHK("link mute", 1'b1, mute_o)
        link(16'h1234, 8'h01);
        axi(0, `ADDR_DAC_WORD, 0);
        `CHK("dac word", 16'h1234, rd[15:0])
        `CHK("adc word", 16'h3FFF, rx_word)
        link(16'h0567, 8'h03);
        axi(0, `ADDR_DAC_WORD, 0);
        `CHK("mixed dac", 16'h0ACE, rd[15:0])
        link(16'h8310, 8'h03);
        `CHK("mixed ctrl", 4'h1, {mute_o, output_gain_select_o})
        axi(0, `ADDR_DAC_WORD, 0);
        `CHK("dac kept", 16'h0ACE, rd[15:0])
        link(16'h0000, 8'h80);
        axi(0, `RA(`CTRL_IDX_B), 0);
        `CHK("soft reset", 8'h00, rd[7:0])
        finish_test();
    end
endmodule
bind codec_digital_core codec_core_chk chk (.clk_i, .rst_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .output_gain_select_o, .mute_o,
    .reference_out_enable_o, .sclk_o, .output_frame_sync_o);
